// ### rtl/bws_host.sv
// host controller driving a byte-wide asynchronous static memory
`timescale 1ns/10ps
// Behaviour
// - a write happens only while low select and strobe are low and high select is high.
// - data setup and hold are timed from the edge that ends the write.
// - a strobe write with gate low lasts at least the float delay plus data setup.
// - the controller never drives data while the memory may be driving it.
// - address is valid no later than the selects are asserted for a read.
// - the strobe stays high through every read.
module bws_host (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              req_valid,
   input  wire bws_pkg::bws_req_t req,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_rdata,
   output bws_pkg::bws_pins_t     pins,
   input  wire logic [7:0]        dq_in
);
   bws_pkg::bws_regs_t r_q;
   bws_pkg::bws_regs_t r_d;

   function automatic logic [bws_pkg::CNT_W-1:0] cyc(input int n);
      cyc = bws_pkg::CNT_W'(n - 1);
   endfunction

   always_comb begin
      r_d = r_q;
      r_d.rsp_valid = 1'b0;
      r_d.cnt = r_q.cnt - 4'h1;
      case (r_q.state)
         bws_pkg::BWS_IDLE: begin
            r_d.pins.strobe_n = 1'b1;
            r_d.pins.dq_oe = 1'b0;
            if (req_valid && r_q.req_ready) begin
               r_d.req_ready = 1'b0;
               // address and selects change together, never selects first
               r_d.pins.addr = req.addr;
               r_d.pins.select_active_low_n = 1'b0;
               r_d.pins.select_active_high = 1'b1;
               if (req.wr) begin
                  // gate stays high so the memory floats the bus at once
                  r_d.pins.gate_n = 1'b1;
                  r_d.pins.strobe_n = 1'b0;
                  r_d.pins.dq_out = req.wdata;
                  r_d.cnt = cyc(bws_pkg::FLOAT_CYC);
                  r_d.state = bws_pkg::BWS_WLOW;
               end else begin
                  r_d.pins.gate_n = 1'b0;
                  r_d.cnt = cyc(bws_pkg::READ_CYC);
                  r_d.state = bws_pkg::BWS_READ;
               end
            end
         end
         bws_pkg::BWS_READ: begin
            if (r_q.cnt == '0) begin
               r_d.rdata = dq_in;
               r_d.rsp_valid = 1'b1;
               r_d.pins.gate_n = 1'b1;
               // selects stay up between accesses is fine, but deselect for standby
               r_d.pins.select_active_low_n = 1'b1;
               r_d.pins.select_active_high = 1'b0;
               r_d.req_ready = 1'b1;
               r_d.state = bws_pkg::BWS_IDLE;
            end
         end
         bws_pkg::BWS_WLOW: begin
            // wait out the float delay before driving the bus
            if (r_q.cnt == '0) begin
               r_d.pins.dq_oe = 1'b1;
               r_d.cnt = cyc(bws_pkg::SETUP_CYC > bws_pkg::PULSE_CYC - bws_pkg::FLOAT_CYC ?
                             bws_pkg::SETUP_CYC : bws_pkg::PULSE_CYC - bws_pkg::FLOAT_CYC);
               r_d.state = bws_pkg::BWS_WDATA;
            end
         end
         bws_pkg::BWS_WDATA: begin
            if (r_q.cnt == '0) begin
               // strobe rise ends the write; data, address, selects held past it
               r_d.pins.strobe_n = 1'b1;
               r_d.cnt = cyc(bws_pkg::HOLD_CYC);
               r_d.state = bws_pkg::BWS_HOLD;
            end
         end
         bws_pkg::BWS_HOLD: begin
            if (r_q.cnt == '0) begin
               r_d.pins.dq_oe = 1'b0;
               r_d.pins.select_active_low_n = 1'b1;
               r_d.pins.select_active_high = 1'b0;
               r_d.rsp_valid = 1'b1;
               r_d.req_ready = 1'b1;
               r_d.state = bws_pkg::BWS_IDLE;
            end
         end
         default: begin
            r_d.state = bws_pkg::BWS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         r_q.state <= bws_pkg::BWS_IDLE;
         r_q.cnt <= '0;
         r_q.req_ready <= 1'b1;
         r_q.rsp_valid <= 1'b0;
         r_q.rdata <= 8'h00;
         r_q.pins.addr <= 17'h00000;
         r_q.pins.select_active_low_n <= 1'b1;
         r_q.pins.select_active_high <= 1'b0;
         r_q.pins.gate_n <= 1'b1;
         r_q.pins.strobe_n <= 1'b1;
         r_q.pins.dq_out <= 8'h00;
         r_q.pins.dq_oe <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign req_ready = r_q.req_ready;
   assign rsp_valid = r_q.rsp_valid;
   assign rsp_rdata = r_q.rdata;
   assign pins = r_q.pins;
endmodule

// ### rtl/bws_pkg.sv
// package for the byte-wide async sram host controller
package bws_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 4;
   // timings in ns, slowest grade figures
   localparam int READ_CYCLE_NS = 20;
   localparam int WRITE_PULSE_NS = 15;
   localparam int DATA_SETUP_NS = 10;
   localparam int STROBE_LOW_TO_FLOAT_NS = 8;
   localparam int ADDR_HOLD_NS = 4;
   // least times round up to whole cycles
   localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOAT_CYC = (STROBE_LOW_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

   typedef enum logic [4:0] {
      BWS_IDLE  = 5'h01,
      BWS_READ  = 5'h02,
      BWS_WLOW  = 5'h04,
      BWS_WDATA = 5'h08,
      BWS_HOLD  = 5'h10
   } bws_state_t;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bws_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              select_active_low_n;
      logic              select_active_high;
      logic              gate_n;
      logic              strobe_n;
      logic [DATA_W-1:0] dq_out;
      logic              dq_oe;
   } bws_pins_t;

   typedef struct packed {
      bws_state_t        state;
      logic [CNT_W-1:0]  cnt;
      logic              req_ready;
      logic              rsp_valid;
      logic [DATA_W-1:0] rdata;
      bws_pins_t         pins;
   } bws_regs_t;
endpackage

// ### tb/bws_chk_assertions.sv
// pin protocol assertions for the sram host controller
`timescale 1ns/10ps
module bws_chk (
   input wire logic               clock,
   input wire logic               rst,
   input wire bws_pkg::bws_pins_t pins
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire sel = !pins.select_active_low_n && pins.select_active_high;
   property p_wr_sel; !pins.strobe_n |-> sel; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe low unselected");
   property p_rd_strobe; !pins.gate_n |-> pins.strobe_n; endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
   property p_no_clash; pins.dq_oe |-> pins.gate_n; endproperty
   a_no_clash: assert property (p_no_clash) else $error("data clash");
   property p_float; $fell(pins.strobe_n) |-> !pins.dq_oe[*2] ##1 pins.dq_oe; endproperty
   a_float: assert property (p_float) else $error("data before float");
   property p_setup; $rose(pins.strobe_n) |-> pins.dq_oe && $past(pins.dq_oe, 3); endproperty
   a_setup: assert property (p_setup) else $error("short data setup");
   property p_hold; $rose(pins.strobe_n) |-> $stable(pins.dq_out) && $stable(pins.addr); endproperty
   a_hold: assert property (p_hold) else $error("data moved at write end");
   property p_addr; sel && $past(sel) |-> $stable(pins.addr); endproperty
   a_addr: assert property (p_addr) else $error("address moved while selected");
   cover property ($rose(pins.strobe_n));
   cover property ($fell(pins.gate_n));
   cover property ($rose(sel));
endmodule
bind bws_host bws_chk u_chk (.clock, .rst, .pins);

// ### tb/bws_sram.sv
// behavioural byte-wide static memory facing the host
`timescale 1ns/10ps
module bws_sram (
   input  wire logic               clock,
   input  wire bws_pkg::bws_pins_t pins,
   output logic [7:0]              dq_in
);
   logic [7:0] mem [131072];
   logic [7:0] bus_q = 8'h5a;
   wire sel = !pins.select_active_low_n && pins.select_active_high;
   wire wr  = sel && !pins.strobe_n;
   wire rd  = sel && !pins.gate_n && pins.strobe_n;
   // byte taken as the write ends, whichever signal ends it
   always @(negedge wr) mem[pins.addr] = dq_in;
   // released pins toggle so a stale byte cannot pass for data
   always @(posedge clock) bus_q <= ~dq_in;
   assign dq_in = pins.dq_oe ? pins.dq_out : rd ? mem[pins.addr] : bus_q;
endmodule

// ### tb/test_bws_host.sv
// self-checking bench for the sram host controller
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_bws_host;
   typedef struct packed {bws_pkg::bws_req_t r; logic [7:0] e;} bws_row_t;
   logic               clock = 0, rst = 1, req_valid = 0, req_ready, rsp_valid;
   bws_pkg::bws_req_t  req = '0;
   logic [7:0]         rsp_rdata, dq_in;
   bws_pkg::bws_pins_t pins;
   int                 fails = 0, tests_run = 0, lat;
   bws_row_t rows [6] = '{{1'b1, 17'h00000, 8'ha5, 8'h00}, {1'b1, 17'h1ffff, 8'h3c, 8'h00},
      {1'b1, 17'h00005, 8'hff, 8'h00}, {1'b0, 17'h1ffff, 8'h00, 8'h3c},
      {1'b0, 17'h00000, 8'h00, 8'ha5}, {1'b0, 17'h00005, 8'h00, 8'hff}};
   bws_host uut (.clock, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .pins,
      .dq_in);
   bws_sram mem_model (.clock, .pins, .dq_in);
   initial forever #2 clock = ~clock;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic idle_chk();
      `CHK("ready", 1'b1, req_ready)
      `CHK("selects", 2'b10, {pins.select_active_low_n, pins.select_active_high})
      `CHK("gate_strobe_oe", 3'b110, {pins.gate_n, pins.strobe_n, pins.dq_oe})
   endtask
   task automatic run(input bws_row_t w);
      @(posedge clock);
      req <= w.r;
      req_valid <= 1;
      @(posedge clock);
      req_valid <= 0;
      lat = 0;
      do begin @(posedge clock); #1 lat++; end while (rsp_valid !== 1 && lat < 20);
      // read ends after the select window, write after float, setup and hold spans
      `CHK("latency", (w.r.wr ? bws_pkg::FLOAT_CYC + bws_pkg::SETUP_CYC + bws_pkg::HOLD_CYC : bws_pkg::READ_CYC), lat)
      if (!w.r.wr) `CHK("rdata", w.e, rsp_rdata)
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      #1 idle_chk();
      $display("reset test done");
      foreach (rows[i]) run(rows[i]);
      $display("row tests done");
      // reset in mid-write must drop every strobe at once
      @(posedge clock);
      req <= rows[1].r;
      req_valid <= 1;
      repeat (3) @(posedge clock);
      rst <= 1;
      req_valid <= 0;
      @(posedge clock);
      #1 idle_chk();
      @(posedge clock);
      rst <= 0;
      $display("mid-write reset test done");
      end_of_test();
   end
   initial begin
      #20000;
      fails++;
      end_of_test();
   end
endmodule
